//--- core/power_down_idle_entry_exit.sv
`include "pwr_seq_consts.svh"

// Contract
// - Exit-select clear: ignore power-down while interrupt pin high.
// - Exit-select set: ignore power-down if any enabled wake pin active.
// - Otherwise power-down is entered normally.
// - Quasi-idle keeps watchdog counting; overflow resets whole device.
// - Quasi-idle blocks interrupts; fetch stopped.
// - Interrupt pin low during quasi-idle completes power-down entry.
// - Quasi-idle on external fetch with no mux tristate-wait or with a preceding external write.
// - Reset exit from power-down works at every clock frequency.
module power_down_idle_entry_exit
    import pwr_seq_pkg::*;
(
    input  wire logic                        core_clk_i,
    input  wire logic                        nrst_i,
    input  wire cpu_req_type                 cpu_req_i,
    input  wire logic                        power_down_exit_select_i,
    input  wire logic                        nmi_pin_n_i,
    input  wire logic [`WAKE_PIN_COUNT-1:0]  wake_pin_i,
    input  wire logic [`WAKE_PIN_COUNT-1:0]  wake_enable_i,
    input  wire logic [`WAKE_PIN_COUNT-1:0]  wake_active_high_i,
    input  wire logic                        ext_irq_i,
    input  wire logic                        wdog_enable_i,
    input  wire logic                        wdog_service_i,
    input  wire logic                        flash_ready_i,
    output cpu_stat_type                     cpu_stat_o,
    output logic                             sys_reset_o,
    output logic                             clk_gate_o,
    output logic                             freq_violation_o
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [`WAKE_PIN_COUNT:0] pins_sync;
    logic                     nmi_n;
    logic [`WAKE_PIN_COUNT-1:0] wake_s;

    // Interrupt pin synced inverted: the cleared reset value then reads as
    // released, not as a low pin that would open power-down for two cycles
    sync2 #(.WIDTH(`WAKE_PIN_COUNT + 1)) sync2_inst (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .async_i    ({~nmi_pin_n_i, wake_pin_i}),
        .sync_o     (pins_sync)
    );

    assign nmi_n  = ~pins_sync[`WAKE_PIN_COUNT];
    assign wake_s = pins_sync[`WAKE_PIN_COUNT-1:0];

    // ------------------------------------------------------------------------
    // Entry decision
    // ------------------------------------------------------------------------
    logic [`WAKE_PIN_COUNT-1:0] wake_hit;
    logic any_wake;
    logic pd_block;
    logic quasi_cond;

    // Per-pin active-level compare, gated by enable
    for (genvar i = 0; i < `WAKE_PIN_COUNT; i++) begin : g_wake
        assign wake_hit[i] = wake_enable_i[i] & (wake_s[i] == wake_active_high_i[i]);
    end

    assign any_wake = |wake_hit;
    // Block conditions selected by the exit source
    assign pd_block = power_down_exit_select_i ? any_wake : nmi_n;
    // Silicon stall conditions when a blocked request arrives
    assign quasi_cond = cpu_req_i.next_fetch_ext
                        & (~cpu_req_i.mux_tristate_wait | cpu_req_i.prev_ext_write);

    // ------------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------------
    pwr_state_type state;
    pwr_state_type next_state;
    logic          wdog_reset;
    logic [7:0]    settle_cnt;

    always_comb begin
        next_state = state;
        unique case (state)
            st_run: begin
                if (cpu_req_i.power_down_instr) begin
                    if (!pd_block)
                        next_state = st_pdown;
                    else if (quasi_cond)
                        next_state = st_quasi;
                end else if (cpu_req_i.idle_instr) begin
                    next_state = st_idle;
                end
            end
            st_idle: begin
                if (ext_irq_i || !nmi_n)
                    next_state = st_waking;
            end
            st_quasi: begin
                if (!nmi_n)
                    next_state = st_pdown;
            end
            st_pdown: begin
                if (ext_irq_i)
                    next_state = st_waking;
            end
            st_waking: begin
                if (flash_ready_i && settle_cnt == 8'h00)
                    next_state = st_run;
            end
            default: next_state = st_run;
        endcase
        // Watchdog reset wins, so outputs never announce a state not taken
        if (wdog_reset) begin
            next_state = st_run;
        end
    end

    // State register; system reset exits any mode at any rate
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= st_run;
        end else if (wdog_reset) begin
            state <= st_run;
        end else begin
            state <= next_state;
        end
    end

    // Flash settle counter, loaded on every wake
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            settle_cnt <= 8'h00;
        end else if (state != st_waking && next_state == st_waking) begin
            settle_cnt <= 8'(`FLASH_SETTLE_CYCLES);
        end else if (settle_cnt != 8'h00) begin
            settle_cnt <= settle_cnt - 8'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Watchdog: runs in every state except clock-stopped power-down
    // ------------------------------------------------------------------------
    logic [`WDOG_WIDTH-1:0] wdog_cnt;
    logic [3:0]             rst_cnt;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wdog_cnt <= `WDOG_RELOAD;
        end else if (!wdog_enable_i || wdog_service_i || wdog_reset) begin
            wdog_cnt <= `WDOG_RELOAD;
        end else if (state != st_pdown) begin
            wdog_cnt <= wdog_cnt + 16'h0001;
        end
    end

    // Overflow stretches a device-wide reset pulse
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_cnt <= 4'h0;
        end else if (wdog_enable_i && wdog_cnt == `WDOG_OVERFLOW && rst_cnt == 4'h0) begin
            rst_cnt <= `SYS_RESET_CYCLES;
        end else if (rst_cnt != 4'h0) begin
            rst_cnt <= rst_cnt - 4'h1;
        end
    end

    assign wdog_reset = (rst_cnt != 4'h0);

    // ------------------------------------------------------------------------
    // Outputs, registered
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cpu_stat_o <= '0;
            sys_reset_o <= 1'b0;
            clk_gate_o <= 1'b0;
        end else begin
            // Fetch stall covers quasi-idle, power-down and flash settling
            cpu_stat_o.fetch_stall   <= next_state inside {st_quasi, st_waking, st_pdown};
            cpu_stat_o.irq_block     <= next_state == st_quasi;
            cpu_stat_o.in_idle       <= next_state == st_idle;
            cpu_stat_o.in_power_down <= next_state == st_pdown;
            cpu_stat_o.pd_ignored    <= state == st_run && cpu_req_i.power_down_instr
                                        && pd_block && !quasi_cond;
            sys_reset_o <= wdog_reset;
            clk_gate_o  <= next_state == st_pdown;
        end
    end

    // Flag idle or interrupt wake above the flash limit; static by build
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            freq_violation_o <= 1'b0;
        end else if (`CPU_CLK_MHZ > `MAX_CLK_MHZ
                     && ((state == st_run && cpu_req_i.idle_instr)
                         || (state == st_pdown && ext_irq_i))) begin
            freq_violation_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    nmi_block_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        state == st_run && cpu_req_i.power_down_instr && !power_down_exit_select_i && nmi_n
        |=> state != st_pdown) else $error("power-down entered with interrupt pin high");

    wake_block_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        state == st_run && cpu_req_i.power_down_instr && power_down_exit_select_i && any_wake
        && !wdog_reset |=> state != st_pdown) else $error("power-down entered with wake active");

    normal_entry_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        state == st_run && cpu_req_i.power_down_instr && !pd_block && !wdog_reset
        |=> state == st_pdown) else $error("power-down not entered");

    quasi_stall_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        state == st_quasi && nmi_n && !wdog_reset
        |=> state == st_quasi && cpu_stat_o.irq_block)
        else $error("interrupts not blocked in quasi-idle");

    quasi_exit_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        state == st_quasi && !nmi_n && !wdog_reset |=> state == st_pdown ##1 clk_gate_o)
        else $error("quasi-idle did not complete power-down");

    wdog_reset_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        wdog_enable_i && wdog_cnt == `WDOG_OVERFLOW && rst_cnt == 4'h0
        |=> ##1 sys_reset_o [*7]) else $error("watchdog overflow gave no reset");

    quasi_entry_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        state == st_run && cpu_req_i.power_down_instr && pd_block && quasi_cond && !wdog_reset
        |=> state == st_quasi) else $error("quasi-idle not entered");

    reset_exit_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        wdog_reset |=> state == st_run) else $error("reset did not leave power-down");

    flash_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        state == st_waking && !flash_ready_i && !wdog_reset |=> state == st_waking)
        else $error("left wake before flash ready");

    pd_cover_c:    cover property (@(posedge core_clk_i) state == st_run ##1 state == st_pdown);
    quasi_cover_c: cover property (@(posedge core_clk_i) state == st_quasi ##1 state == st_pdown);
    wake_cover_c:  cover property (@(posedge core_clk_i) state == st_waking ##1 state == st_run);
    wdog_cover_c:  cover property (@(posedge core_clk_i) state == st_quasi && wdog_reset);

endmodule : power_down_idle_entry_exit

//--- core/pwr_seq_consts.svh
`ifndef PWR_SEQ_CONSTS_SVH
`define PWR_SEQ_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths, reset values and timing
// ----------------------------------------------------------------------------
`define WAKE_PIN_COUNT       8
`define WDOG_WIDTH           16
`define WDOG_RELOAD          16'h0000
`define WDOG_OVERFLOW        16'hFFFF
`define SYS_RESET_CYCLES     4'h8
`define CLK_PERIOD_NS        10
`define FLASH_SETTLE_NS      200
`define FLASH_SETTLE_CYCLES  ((`FLASH_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_CLK_MHZ          55
`define CPU_CLK_MHZ          100

`endif

//--- core/pwr_seq_pkg.sv
package pwr_seq_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        st_run     = 3'b000,
        st_idle    = 3'b001,
        st_quasi   = 3'b010,
        st_pdown   = 3'b011,
        st_waking  = 3'b100
    } pwr_state_type;

    // Request bundle from the CPU core
    typedef struct packed {
        logic idle_instr;
        logic power_down_instr;
        logic prev_ext_write;
        logic next_fetch_ext;
        logic mux_tristate_wait;
    } cpu_req_type;

    // Status bundle back to the CPU core
    typedef struct packed {
        logic fetch_stall;
        logic irq_block;
        logic in_idle;
        logic in_power_down;
        logic pd_ignored;
    } cpu_stat_type;

endpackage : pwr_seq_pkg

//--- core/sync2.sv
// Two-flop synchroniser for pin inputs, one per bit
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk_i,
    input  wire logic             nrst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule : sync2

//--- sim/cpu_core_model.sv
// Behavioural CPU core: issues idle and power-down instruction pulses
module cpu_core_model
    import pwr_seq_pkg::*;
(
    input  wire logic         core_clk_i,
    input  wire cpu_stat_type cpu_stat_i,
    output cpu_req_type       cpu_req_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cpu_req_o = '0;

    // ------------------------------------------------------------------------
    // One instruction, launched and withdrawn on falling edges
    // ------------------------------------------------------------------------
    // A stalled core fetches nothing, so it cannot issue while stalled
    task automatic issue(input logic idle, input logic pd, input logic wr,
                         input logic ext, input logic mux);
        @(negedge core_clk_i);
        if (cpu_stat_i.fetch_stall !== 1'b1) begin
            cpu_req_o.idle_instr        = idle; // idle only when a scenario asks
            cpu_req_o.power_down_instr  = pd;
            cpu_req_o.prev_ext_write    = wr;   // external write only on request
            cpu_req_o.next_fetch_ext    = ext;
            cpu_req_o.mux_tristate_wait = mux;
        end
        @(negedge core_clk_i);
        cpu_req_o = '0;
    endtask : issue
endmodule : cpu_core_model

//--- sim/power_down_idle_entry_exit_tb.sv
`include "pwr_seq_consts.svh"

module power_down_idle_entry_exit_tb;
    import pwr_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                       core_clk_i = 1'b0;
    logic                       nrst_i     = 1'b0;
    cpu_req_type                cpu_req;
    cpu_stat_type               cpu_stat_o;
    logic                       sel        = 1'b0;
    logic                       nmi_n      = 1'b1;
    logic [`WAKE_PIN_COUNT-1:0] pins       = 8'hF0;
    logic                       ext_irq    = 1'b0;
    logic                       wdog_en    = 1'b0;
    logic                       flash_rdy  = 1'b1;
    logic                       sys_reset_o;
    logic                       clk_gate_o;
    logic                       freq_violation_o;
    int                         errors     = 0;
    int                         tests_run  = 0;
    int                         cycles     = 0;
    // Entry table: {select, interrupt pin}, pins, ignored
    logic [1:0] mode [6] = '{2'h1, 2'h0, 2'h3, 2'h3, 2'h3, 2'h3};
    logic [7:0] pval [6] = '{8'hF0, 8'hF0, 8'hF4, 8'hF2, 8'hE0, 8'hF0};
    logic       ign  [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    always #5 core_clk_i = ~core_clk_i;

    power_down_idle_entry_exit power_down_idle_entry_exit_inst (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .cpu_req_i(cpu_req),
        .power_down_exit_select_i(sel), .nmi_pin_n_i(nmi_n), .wake_pin_i(pins),
        .wake_enable_i(8'h15), .wake_active_high_i(8'h0F), .ext_irq_i(ext_irq),
        .wdog_enable_i(wdog_en), .wdog_service_i(1'b0), .flash_ready_i(flash_rdy),
        .cpu_stat_o(cpu_stat_o), .sys_reset_o(sys_reset_o), .clk_gate_o(clk_gate_o),
        .freq_violation_o(freq_violation_o));

    cpu_core_model cpu_core_model_inst (
        .core_clk_i(core_clk_i), .cpu_stat_i(cpu_stat_o), .cpu_req_o(cpu_req));

    // ------------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------------
    task automatic complete_run;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : cyc

    // Pins pass two sync flops, so let them settle after release
    task automatic do_reset;
        @(negedge core_clk_i) nrst_i = 1'b0;
        cyc(12);
        nrst_i = 1'b1;
        cyc(3);
    endtask : do_reset

    // Interrupt wake with slow flash; fetch must wait for ready
    task automatic wake;
        int n;
        flash_rdy = 1'b0;
        ext_irq   = 1'b1;
        cyc(2);
        ext_irq = 1'b0;
        check(cpu_stat_o.in_power_down | cpu_stat_o.in_idle, 0, "still asleep");
        check(freq_violation_o, 1, "no frequency flag on irq wake");
        cyc(30);
        check(cpu_stat_o.fetch_stall, 1, "fetch before flash ready");
        flash_rdy = 1'b1;
        for (n = 0; n < 30 && cpu_stat_o.fetch_stall !== 1'b0; n++) cyc(1);
        check(cpu_stat_o.fetch_stall, 0, "fetch never resumed");
    endtask : wake

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic entry_table;
        for (int i = 0; i < 6; i++) begin
            {sel, nmi_n} = mode[i];
            pins         = pval[i];
            cyc(3);
            cpu_core_model_inst.issue(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
            check(cpu_stat_o.pd_ignored, ign[i], "ignore decision");
            check(cpu_stat_o.in_power_down, !ign[i], "entry decision");
            check(clk_gate_o, !ign[i], "clock gate");
            if (!ign[i]) wake();
        end
        {sel, nmi_n, pins} = {2'h1, 8'hF0};
        sel = 1'b0;
    endtask : entry_table

    task automatic quasi_idle;
        logic wr [3] = '{1'b0, 1'b1, 1'b0};
        logic mx [3] = '{1'b0, 1'b1, 1'b1};
        logic st [3] = '{1'b1, 1'b1, 1'b0};
        for (int k = 0; k < 3; k++) begin
            cpu_core_model_inst.issue(1'b0, 1'b1, wr[k], 1'b1, mx[k]);
            check(cpu_stat_o.fetch_stall, st[k], "quasi-idle entry");
            check(cpu_stat_o.pd_ignored, !st[k], "plain ignore");
            if (st[k]) begin
                check(cpu_stat_o.irq_block, 1, "irq not blocked");
                ext_irq = 1'b1;
                cyc(3);
                ext_irq = 1'b0;
                check(cpu_stat_o.fetch_stall, 1, "irq served in stall");
                nmi_n = 1'b0;
                cyc(4);
                check(cpu_stat_o.in_power_down, 1, "no entry on pin low");
                wake();
                nmi_n = 1'b1;
                cyc(3);
            end
        end
    endtask : quasi_idle

    // Fresh reset first, so the sticky frequency flag starts clear
    task automatic idle_use;
        do_reset();
        check(freq_violation_o, 0, "frequency flag after reset");
        cpu_core_model_inst.issue(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        check(cpu_stat_o.in_idle, 1, "idle not entered");
        check(freq_violation_o, 1, "no idle frequency flag");
        // Flash ready at once: fetch must still wait out the settle count
        ext_irq = 1'b1;
        cyc(1);
        ext_irq = 1'b0;
        check(cpu_stat_o.in_idle, 0, "idle not left on irq");
        cyc(`FLASH_SETTLE_CYCLES);
        check(cpu_stat_o.fetch_stall, 1, "fetch before settle");
        cyc(2);
        check(cpu_stat_o.fetch_stall, 0, "fetch after settle");
        cpu_core_model_inst.issue(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        wake();
    endtask : idle_use

    task automatic reset_exit;
        nmi_n = 1'b0;
        cyc(3);
        cpu_core_model_inst.issue(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        check(cpu_stat_o.in_power_down, 1, "power-down missed");
        do_reset();
        check({cpu_stat_o, clk_gate_o, freq_violation_o}, 0, "reset exit");
        cpu_core_model_inst.issue(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        check(cpu_stat_o.in_power_down, 1, "no entry after reset");
        wake();
        nmi_n = 1'b1;
        cyc(3);
    endtask : reset_exit

    task automatic watchdog_stall;
        int n;
        wdog_en = 1'b1;
        cpu_core_model_inst.issue(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        check(cpu_stat_o.fetch_stall, 1, "stall missed");
        for (n = 0; n < 70000 && sys_reset_o !== 1'b1; n++) cyc(1);
        check(sys_reset_o, 1, "watchdog silent in stall");
        for (n = 0; n < 20 && sys_reset_o === 1'b1; n++) cyc(1);
        check(n, `SYS_RESET_CYCLES, "reset pulse length");
        check(cpu_stat_o.fetch_stall, 0, "stall after watchdog reset");
        wdog_en = 1'b0;
    endtask : watchdog_stall

    // Hang guard, well beyond one watchdog period
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        do_reset();
        entry_table();
        quasi_idle();
        idle_use();
        reset_exit();
        watchdog_stall();
        complete_run();
    end
endmodule : power_down_idle_entry_exit_tb
